// *** src/qec_counter.sv ***
// Quadrature encoder counter: decodes A/B/index, keeps a wrapping count,
// direction, index status and a velocity estimate in rad/s.
// Assumes encoder pins are asynchronous to clk_sys_in; config is static or synchronous.
`timescale 1ns/10ps
// Overview of operation
// - A forward edge with the count at the maximum wraps the count to zero.
// - A reverse edge with the count at zero loads the maximum into the count.
// - A counting-mode input selects which A and B transitions produce count steps.
// - A direction input selects which rising-edge order of A and B counts up.
// - A reset-method input chooses index-pulse clearing or wrap-only clearing.
// - A reset-condition input gives the A and B levels that qualify an index reset; its index bit must be set.
// - With the index enabled, a qualifying index pulse clears the count to zero.
// - An input-type setting selects single-ended or differential reception of each signal.
// - Differential mode uses the complement input; single-ended mode ignores it.
// - With the index disabled, the index inputs are ignored entirely.
// - The count and a status word with direction and an index-seen flag are output.
// - The mean angular velocity in rad/s over the last update interval is output alongside the count.
module qec_counter #(
    parameter int CNT_W      = qec_pkg::CNT_W_DEF,
    parameter int UPDATE_CYC = qec_pkg::UPDATE_CYC
) (
    input  wire logic                      clk_sys_in,
    input  wire logic                      reset_in,
    input  wire qec_pkg::qec_sig_t         pos_in,
    input  wire qec_pkg::qec_sig_t         neg_in,
    input  wire qec_pkg::qec_cfg_t         cfg_in,
    input  wire logic [CNT_W-1:0]          max_count_in,
    output logic [CNT_W-1:0]               count_out,
    output qec_pkg::qec_status_t           status_out,
    output logic signed [qec_pkg::VEL_W-1:0] velocity_out
);

    // Receiver: differential recovers the level only when the pair disagrees
    function automatic logic rx_level(input logic p, input logic n, input logic diff);
        begin
            rx_level = diff ? (p & ~n) : p;
        end
    endfunction : rx_level

    // Two flops on every pin, true and complement alike
    qec_pkg::qec_sig_t pos_s1_reg;
    qec_pkg::qec_sig_t pos_s2_reg;
    qec_pkg::qec_sig_t neg_s1_reg;
    qec_pkg::qec_sig_t neg_s2_reg;
    qec_pkg::qec_sig_t prev_reg;
    qec_pkg::qec_sig_t lvl;
    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            pos_s1_reg <= '0;
            pos_s2_reg <= '0;
            neg_s1_reg <= '0;
            neg_s2_reg <= '0;
            prev_reg   <= '0;
        end
        else
        begin
            pos_s1_reg <= pos_in;
            pos_s2_reg <= pos_s1_reg;
            neg_s1_reg <= neg_in;
            neg_s2_reg <= neg_s1_reg;
            prev_reg   <= lvl;
        end
    end

    // Complement used or ignored
    // Pair combined after the flops, so no gate sees a raw pin
    always_comb
    begin
        lvl.a   = rx_level(pos_s2_reg.a, neg_s2_reg.a, cfg_in.differential);
        lvl.b   = rx_level(pos_s2_reg.b, neg_s2_reg.b, cfg_in.differential);
        lvl.idx = rx_level(pos_s2_reg.idx, neg_s2_reg.idx, cfg_in.differential);
    end

    logic a_chg;
    logic b_chg;
    logic step_up;
    logic step_dn;
    logic idx_clear;
    logic phase_fwd;
    logic valid_step;

    always_comb
    begin
        a_chg = lvl.a ^ prev_reg.a;
        b_chg = lvl.b ^ prev_reg.b;
        // Natural forward sense: A leads B (A changes, new A differs from B)
        phase_fwd = a_chg ? (lvl.a ^ lvl.b) : ~(lvl.a ^ lvl.b);
        valid_step = a_chg ^ b_chg;
        unique case (cfg_in.mode)
            qec_pkg::QEC_MODE_X4: valid_step = valid_step;
            qec_pkg::QEC_MODE_X2: valid_step = valid_step & a_chg;
            qec_pkg::QEC_MODE_X1: valid_step = valid_step & a_chg & lvl.a;
            default:              valid_step = 1'b0;
        endcase
        step_up = valid_step & (phase_fwd ^ cfg_in.dir_b_first);
        step_dn = valid_step & ~(phase_fwd ^ cfg_in.dir_b_first);
        idx_clear = cfg_in.index_enable & cfg_in.reset_by_index
                    & lvl.idx & ~prev_reg.idx
                    & (lvl.a == cfg_in.reset_cond.a)
                    & (lvl.b == cfg_in.reset_cond.b)
                    & cfg_in.reset_cond.idx;
    end

    // Count and direction state
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic             dir_reg;
    logic             dir_next;
    always_comb
    begin
        count_next = count_reg;
        dir_next   = dir_reg;
        // Direction tracks every step, even one masked by an index clear
        if (step_up)
            dir_next = 1'b1;
        else if (step_dn)
            dir_next = 1'b0;
        if (idx_clear)
            count_next = '0;
        else if (step_up)
        begin
            if (count_reg >= max_count_in)
                count_next = '0;
            else
                count_next = count_reg + 1'b1;
        end
        else if (step_dn)
        begin
            if (count_reg == '0)
                count_next = max_count_in;
            else
                count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            count_reg <= '0;
            dir_reg   <= 1'b1;
        end
        else
        begin
            count_reg <= count_next;
            dir_reg   <= dir_next;
        end
    end

    // Update interval: index flag and velocity refresh once per interval
    localparam int VEL_LOC = qec_pkg::VEL_W;
    logic [31:0]             tick_reg;
    logic [31:0]             tick_next;
    logic                    idx_acc_reg;
    logic                    idx_acc_next;
    logic                    idx_seen_reg;
    logic                    idx_seen_next;
    logic signed [31:0]      delta_reg;
    logic signed [31:0]      delta_next;
    logic signed [VEL_LOC-1:0] vel_reg;
    logic signed [VEL_LOC-1:0] vel_next;
    logic                    interval_end;
    logic signed [63:0]      vel_wide;

    always_comb
    begin
        interval_end  = (tick_reg == 32'(UPDATE_CYC - 1));
        tick_next     = interval_end ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
        delta_next    = delta_reg;
        if (step_up)
            delta_next = delta_reg + 32'sh0000_0001;
        else if (step_dn)
            delta_next = delta_reg - 32'sh0000_0001;
        idx_acc_next  = idx_acc_reg | idx_clear;
        idx_seen_next = idx_seen_reg;
        vel_next      = vel_reg;
        // Steps per interval to rad/s; needs max
        vel_wide = 64'(delta_next) * 64'(qec_pkg::TWO_PI_Q16) * 64'(qec_pkg::CLK_HZ / UPDATE_CYC)
                   / $signed(64'({1'b0, max_count_in}) + 64'h0000_0000_0000_0001);
        // Divisor kept signed, else reverse motion reads as a huge speed
        if (interval_end)
        begin
            idx_seen_next = idx_acc_next;
            idx_acc_next  = 1'b0;
            vel_next      = vel_wide[VEL_LOC-1:0];
            delta_next    = 32'sh0000_0000;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (reset_in)
        begin
            tick_reg     <= 32'h0000_0000;
            idx_acc_reg  <= 1'b0;
            idx_seen_reg <= 1'b0;
            delta_reg    <= 32'sh0000_0000;
            vel_reg      <= '0;
        end
        else
        begin
            tick_reg     <= tick_next;
            idx_acc_reg  <= idx_acc_next;
            idx_seen_reg <= idx_seen_next;
            delta_reg    <= delta_next;
            vel_reg      <= vel_next;
        end
    end

    always_comb
    begin
        count_out           = count_reg;
        status_out.dir_fwd  = dir_reg;
        status_out.idx_seen = idx_seen_reg;
        velocity_out        = vel_reg;
    end

    a_fwd_wrap_zero: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (step_up && !idx_clear && count_reg == max_count_in) |=> count_reg == '0)
        else $error("forward wrap did not reach zero");
    a_rev_wrap_max: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (step_dn && !idx_clear && count_reg == '0) |=> count_reg == $past(max_count_in))
        else $error("reverse wrap did not load maximum");
    a_idx_clears: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        idx_clear |=> count_reg == '0)
        else $error("index pulse did not clear count");
    a_idx_disabled: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (!cfg_in.index_enable && !step_up && !step_dn) |=> $stable(count_reg))
        else $error("count moved with index disabled and no step");
    a_double_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (a_chg && b_chg && !idx_clear) |=> $stable(count_reg))
        else $error("count moved on double change");
    a_sync_delay: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        !$past(reset_in, 2) |-> (pos_s2_reg == $past(pos_in, 2)
                                 && neg_s2_reg == $past(neg_in, 2)))
        else $error("synchroniser latency wrong");
    a_dir_follows: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        step_dn |=> !status_out.dir_fwd)
        else $error("direction not reverse after down step");
    // Single mode counts A rising only
    a_mode_x1: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (cfg_in.mode == qec_pkg::QEC_MODE_X1 && (step_up || step_dn)) |-> a_chg && lvl.a)
        else $error("x1 mode counted a non A-rising edge");

endmodule : qec_counter

// *** src/qec_pkg.sv ***
// Package for the quadrature encoder counter: modes, status layout, constants.
// Assumes a single 250 MHz system clock domain.
package qec_pkg;

    localparam int CNT_W_DEF      = 32;
    localparam int VEL_W          = 32;
    localparam int SYNC_STAGES    = 2;
    localparam int CLK_HZ         = 250_000_000;
    // Update interval for index flag and velocity, in microseconds
    localparam int UPDATE_US      = 100;
    localparam int UPDATE_CYC     = CLK_HZ / 1_000_000 * UPDATE_US;
    // Velocity scale: rad/s in Q16.16 fixed point, 2*pi scaled by 2^16
    localparam int TWO_PI_Q16     = 411775;
    localparam int FRAC_BITS      = 16;
    localparam int STAT_DIR_BIT   = 0;
    localparam int STAT_IDX_BIT   = 1;

    // Counting modes: every edge of A and B, A edges only, A rising only
    typedef enum logic [1:0]
    {
        QEC_MODE_X4 = 2'b00,
        QEC_MODE_X2 = 2'b01,
        QEC_MODE_X1 = 2'b10
    } qec_mode_t;

    typedef struct packed
    {
        logic a;
        logic b;
        logic idx;
    } qec_sig_t;

    typedef struct packed
    {
        qec_mode_t  mode;
        logic       dir_b_first;
        logic       reset_by_index;
        qec_sig_t   reset_cond;
        logic       differential;
        logic       index_enable;
    } qec_cfg_t;

    typedef struct packed
    {
        logic idx_seen;
        logic dir_fwd;
    } qec_status_t;

endpackage : qec_pkg

// *** verif/qec_enc_model.sv ***
// Encoder model: drives true and complement lines from phase moves.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/10ps
module qec_enc_model (
    input  wire logic         clk_in,
    input  wire logic         diff_in,
    output qec_pkg::qec_sig_t pos_out,
    output qec_pkg::qec_sig_t neg_out
);
    logic [1:0]        ph_reg;
    qec_pkg::qec_sig_t junk_reg;

    initial
    begin
        ph_reg = 2'h0;
        pos_out = '0;
        junk_reg = '0;
    end

    // Unused complement toggles so a stray use cannot look valid
    always @(posedge clk_in)
        junk_reg <= ~junk_reg;

    assign neg_out = diff_in ? ~pos_out : junk_reg;

    // Gray phases 0..3 give (a,b) 00,10,11,01; a move of 2 changes both
    task automatic move(input int n);
        ph_reg = ph_reg + n[1:0];
        pos_out.a = ph_reg[0] ^ ph_reg[1];
        pos_out.b = ph_reg[1];
    endtask : move

    task automatic pulse();
        pos_out.idx = 1'b1;
        repeat (4) @(posedge clk_in);
        #1 pos_out.idx = 1'b0;
    endtask : pulse
endmodule : qec_enc_model

// *** verif/tb.sv ***
// Self-checking bench for the encoder counter, small count and interval.
// Assumes the encoder model drives the pins; notes expected counts in a queue.
`timescale 1ns/10ps
module tb;
    localparam int CW = 8;
    localparam int UC = 50;
    logic                             clk_sys_in;
    logic                             reset_in;
    qec_pkg::qec_sig_t                pos;
    qec_pkg::qec_sig_t                neg;
    qec_pkg::qec_cfg_t                cfg;
    logic [CW-1:0]                    max_c;
    logic [CW-1:0]                    count;
    logic [CW-1:0]                    exp_c;
    logic [CW-1:0]                    prev;
    qec_pkg::qec_status_t             st;
    logic signed [qec_pkg::VEL_W-1:0] vel;
    logic [CW-1:0]                    q[$];
    int                               miscompares = 0;
    int                               n_compared = 0;

    qec_enc_model enc (.clk_in(clk_sys_in), .diff_in(cfg.differential),
                       .pos_out(pos), .neg_out(neg));
    qec_counter #(.CNT_W(CW), .UPDATE_CYC(UC)) DUT (.clk_sys_in(clk_sys_in),
        .reset_in(reset_in), .pos_in(pos), .neg_in(neg), .cfg_in(cfg),
        .max_count_in(max_c), .count_out(count), .status_out(st), .velocity_out(vel));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic give_verdict();
        if (miscompares == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // One pin move; eff is the expected count step (+1, -1 or none)
    task automatic step(input int n, input int eff);
        enc.move(n);
        if (eff != 0)
        begin
            exp_c = (eff > 0) ? ((exp_c == max_c) ? '0 : exp_c + 1'b1)
                              : ((exp_c == '0) ? max_c : exp_c - 1'b1);
            q.push_back(exp_c);
        end
        repeat (4 + $urandom_range(3)) @(posedge clk_sys_in);
        #1;
    endtask : step

    initial
    begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end

    // Oldest note is taken whenever the count moves
    always @(negedge clk_sys_in)
    begin
        if (!reset_in && count !== prev)
            check(count, q.size() ? q.pop_front() : ~count);
        prev = count;
    end

    initial
    begin
        #80000;
        miscompares++;
        give_verdict();
    end

    initial
    begin
        int i;
        int k;
        int d;
        i = $urandom(26);
        reset_in = 1'b1;
        prev = '0;
        exp_c = '0;
        cfg = {qec_pkg::QEC_MODE_X4, 1'b0, 1'b1, 3'b001, 1'b1, 1'b1};
        // Two line pairs, four edges each, minus one
        max_c = 8'h07;
        repeat (4) @(posedge clk_sys_in);
        #1 reset_in = 1'b0;
        @(posedge clk_sys_in);
        #1 enc.move(1);
        q.push_back(8'h01);
        exp_c = 8'h01;
        repeat (2) @(posedge clk_sys_in);
        #1 check(count, 8'h00);
        @(posedge clk_sys_in);
        #1 check(count, 8'h01);
        repeat (12) step(1, 1);
        check(st.dir_fwd, 1'b1);
        repeat (12) step(-1, -1);
        check(st.dir_fwd, 1'b0);
        for (i = 0; i < 20; i++)
        begin
            d = $urandom_range(1) ? 1 : -1;
            step(d, d);
        end
        cfg.dir_b_first = 1'b1;
        repeat (5) step(1, -1);
        repeat (3) step(-1, 1);
        cfg.dir_b_first = 1'b0;
        // Modes x2, x1 and no count
        for (i = 1; i < 4; i++)
        begin
            cfg.mode = qec_pkg::qec_mode_t'(i);
            repeat (4) step(1, i == 1 ? !enc.ph_reg[0] : i == 2 ? enc.ph_reg == 0 : 0);
        end
        cfg.mode = qec_pkg::QEC_MODE_X4;
        // Both lines at once, then normal step
        step(2, 0);
        step(1, 1);
        while (enc.ph_reg != 0)
            step(1, 1);
        for (k = 0; k < 4; k++)
        begin
            repeat (exp_c == 4 ? 8 : 4) step(1, 1);
            cfg.reset_by_index = (k != 1);
            cfg.index_enable = (k != 2);
            cfg.reset_cond.a = (k == 3);
            if (k == 0)
            begin
                exp_c = '0;
                q.push_back('0);
            end
            enc.pulse();
            // Watch up to two full intervals past the pulse; only the qualified one may flag
            for (i = 0; i < 2 * UC; i++)
            begin
                if (st.idx_seen === 1'b1)
                    break;
                @(posedge clk_sys_in);
                #1;
            end
            check(st.idx_seen, k == 0);
            // Let the flag fall before the next variant
            repeat (2 * UC) @(posedge clk_sys_in);
            #1 cfg = {qec_pkg::QEC_MODE_X4, 1'b0, 1'b1, 3'b001, 1'b1, 1'b1};
        end
        cfg.differential = 1'b0;
        repeat (6) step(1, 1);
        repeat (3 * UC) @(posedge clk_sys_in);
        #1 check(vel, 32'h0000_0000);
        check(q.size(), 32'h0000_0000);
        give_verdict();
    end
endmodule : tb
